// *** rtl/auv_pkg.sv ***
// Constants and types for the accumulator velocity and user variable command block
package auv_pkg;
   localparam int FRAME_BYTES = 9;
   localparam logic [3:0] IDX_ADDR = 4'h0;
   localparam logic [3:0] IDX_OPCODE = 4'h1;
   localparam logic [3:0] IDX_TYPE = 4'h2;
   localparam logic [3:0] IDX_BANK = 4'h3;
   localparam logic [3:0] IDX_VAL3 = 4'h4;
   localparam logic [3:0] IDX_VAL0 = 4'h7;
   localparam logic [3:0] IDX_CSUM = 4'h8;
   localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
   localparam logic [7:0] OP_ROTATE_RIGHT = 8'h33;
   localparam logic [7:0] OP_STORE_DIRECT = 8'h37;
   localparam logic [7:0] OP_LOAD_VAR = 8'h38;
   localparam logic [7:0] OP_STORE_ACCUM = 8'h39;
   localparam logic [7:0] OP_USER_FIRST = 8'h40;
   localparam logic [7:0] OP_USER_LAST = 8'h47;
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] PARAM_TARGET_VEL = 8'h02;
   localparam int VAR_DEPTH = 256;
   localparam int VAR_ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;
   localparam logic [31:0] X_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] cmdType;
      logic [7:0] bank;
      logic [31:0] value;
   } auv_cmd_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] opcode;
      logic [31:0] value;
   } auv_reply_t;
endpackage

// *** rtl/auv_var_mem.sv ***
// User variable store with registered read data
`timescale 1ns/1ps
`default_nettype none
module auv_var_mem #(
   parameter int DEPTH = 256,
   parameter int ADDR_W = 8,
   parameter int WIDTH = 32
) (
   input wire logic sys_clk,
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic rdEn,
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   // No reset on the array so it maps onto block memory
   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule
`default_nettype wire

// *** rtl/auv_frame_rx.sv ***
// Command frame assembler with address match and checksum check
`timescale 1ns/1ps
`default_nettype none
module auv_frame_rx #(
   parameter logic [7:0] MODULE_ADDR = auv_pkg::DEF_MODULE_ADDR
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic rxReady,
   output logic frameValid,
   output auv_pkg::auv_cmd_t frame,
   input wire logic frameReady,
   output logic csumError
);
   import auv_pkg::*;

   logic [3:0] byteIdx_q;
   logic [7:0] sum_q;
   logic addrOk_q;
   logic frameValid_q;
   auv_cmd_t frame_q;
   logic take;

   // Hold off the byte stream while a finished frame waits
   assign rxReady = !frameValid_q;
   assign take = rxValid && rxReady;
   assign frameValid = frameValid_q;
   assign frame = frame_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         byteIdx_q <= 4'h0;
         sum_q <= 8'h00;
      end else if (take) begin
         if (byteIdx_q == IDX_CSUM) begin
            byteIdx_q <= 4'h0;
            sum_q <= 8'h00;
         end else begin
            byteIdx_q <= byteIdx_q + 4'h1;
            sum_q <= sum_q + rxData;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addrOk_q <= 1'b0;
         frame_q <= '0;
      end else if (take) begin
         unique case (byteIdx_q)
            IDX_ADDR: addrOk_q <= (rxData == MODULE_ADDR);
            IDX_OPCODE: frame_q.opcode <= rxData;
            IDX_TYPE: frame_q.cmdType <= rxData;
            IDX_BANK: frame_q.bank <= rxData;
            IDX_CSUM: ;
            default: frame_q.value <= {frame_q.value[23:0], rxData};
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frameValid_q <= 1'b0;
         csumError <= 1'b0;
      end else begin
         csumError <= 1'b0;
         if (frameValid_q && frameReady) begin
            frameValid_q <= 1'b0;
         end
         if (take && byteIdx_q == IDX_CSUM) begin
            if (rxData != sum_q) begin
               csumError <= 1'b1;
            end else if (addrOk_q) begin
               frameValid_q <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/auv_cmd_exec.sv ***
// Command executor for rotate-right, indexed variables and user extensions
`timescale 1ns/1ps
`default_nettype none
module auv_cmd_exec #(
   parameter logic [7:0] MODULE_ADDR = auv_pkg::DEF_MODULE_ADDR
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic rxReady,
   output logic csumError,
   input wire logic progValid,
   input wire auv_pkg::auv_cmd_t progCmd,
   output logic progReady,
   output logic replyValid,
   output auv_pkg::auv_reply_t reply,
   input wire logic replyReady,
   input wire logic accWrValid,
   input wire logic [31:0] accWrData,
   input wire logic xWrValid,
   input wire logic [31:0] xWrData,
   output logic [31:0] accum,
   output logic [31:0] xIndex,
   output logic velocityMode,
   output logic dirIncrement,
   output logic paramWrValid,
   output logic [7:0] paramWrIndex,
   output logic [31:0] paramWrData,
   output logic userOpValid,
   output auv_pkg::auv_cmd_t userOpCmd
);
   import auv_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_VELMODE = 3'b001,
      ST_VELSET = 3'b010,
      ST_READ = 3'b011,
      ST_LOAD = 3'b100,
      ST_REPLY = 3'b101
   } auv_state_t;

   auv_state_t state_q;
   auv_cmd_t cmd_q;
   logic direct_q;
   logic frameValid;
   logic frameReady;
   auv_cmd_t frame;
   logic accept;
   logic fromFrame;
   auv_cmd_t inCmd;
   logic idxOk;
   logic isUser;
   logic isOurs;
   logic memWrEn;
   logic [31:0] memWrData;
   logic [31:0] memRdData;
   logic [31:0] acc_q;
   logic [31:0] x_q;
   auv_reply_t reply_q;

   auv_frame_rx #(
      .MODULE_ADDR(MODULE_ADDR)
   ) frameRx (
      .sys_clk(sys_clk),
      .rst(rst),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxReady(rxReady),
      .frameValid(frameValid),
      .frame(frame),
      .frameReady(frameReady),
      .csumError(csumError)
   );

   // Host frames win over the stored program when both wait
   assign fromFrame = frameValid;
   assign inCmd = fromFrame ? frame : progCmd;
   assign accept = (state_q == ST_IDLE) && (frameValid || progValid);
   assign frameReady = (state_q == ST_IDLE);
   assign progReady = (state_q == ST_IDLE) && !frameValid;

   // Signed index must be 0..255, so all upper bits zero
   assign idxOk = (x_q[31:VAR_ADDR_W] == '0);
   assign isUser = (inCmd.opcode >= OP_USER_FIRST) && (inCmd.opcode <= OP_USER_LAST);
   assign isOurs = isUser || inCmd.opcode == OP_ROTATE_RIGHT || inCmd.opcode == OP_STORE_DIRECT
      || inCmd.opcode == OP_LOAD_VAR || inCmd.opcode == OP_STORE_ACCUM;

   // Indexed variable access is allowed from either source alike
   assign memWrEn = accept && idxOk && (inCmd.opcode == OP_STORE_DIRECT
      || inCmd.opcode == OP_STORE_ACCUM);
   assign memWrData = (inCmd.opcode == OP_STORE_DIRECT) ? inCmd.value : acc_q;

   auv_var_mem #(
      .DEPTH(VAR_DEPTH),
      .ADDR_W(VAR_ADDR_W),
      .WIDTH(DATA_W)
   ) varMem (
      .sys_clk(sys_clk),
      .wrEn(memWrEn),
      .wrAddr(x_q[VAR_ADDR_W-1:0]),
      .wrData(memWrData),
      .rdEn(accept && inCmd.opcode == OP_LOAD_VAR),
      .rdAddr(x_q[VAR_ADDR_W-1:0]),
      .rdData(memRdData)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (accept && isOurs) begin
                  if (inCmd.opcode == OP_ROTATE_RIGHT) begin
                     state_q <= ST_VELMODE;
                  end else if (inCmd.opcode == OP_LOAD_VAR && idxOk) begin
                     state_q <= ST_READ;
                  end else if (fromFrame) begin
                     state_q <= ST_REPLY;
                  end
               end
            end
            ST_VELMODE: state_q <= ST_VELSET;
            ST_VELSET: state_q <= direct_q ? ST_REPLY : ST_IDLE;
            ST_READ: state_q <= ST_LOAD;
            ST_LOAD: state_q <= direct_q ? ST_REPLY : ST_IDLE;
            ST_REPLY: begin
               if (replyReady) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_q <= '0;
         direct_q <= 1'b0;
      end else if (accept) begin
         cmd_q <= inCmd;
         direct_q <= fromFrame;
      end
   end

   // Type, bank and value of rotate-right are never looked at
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         velocityMode <= 1'b0;
         dirIncrement <= 1'b0;
      end else if (state_q == ST_VELMODE) begin
         velocityMode <= 1'b1;
         dirIncrement <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         paramWrValid <= 1'b0;
         paramWrIndex <= 8'h00;
         paramWrData <= 32'h0000_0000;
      end else begin
         paramWrValid <= (state_q == ST_VELSET);
         if (state_q == ST_VELSET) begin
            paramWrIndex <= PARAM_TARGET_VEL;
            paramWrData <= acc_q;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q <= ACC_RESET;
      end else if (state_q == ST_LOAD) begin
         acc_q <= memRdData;
      end else if (accWrValid) begin
         acc_q <= accWrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         x_q <= X_RESET;
      end else if (xWrValid) begin
         x_q <= xWrData;
      end
   end

   // Extension codes only pass out; their meaning lives elsewhere
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         userOpValid <= 1'b0;
         userOpCmd <= '0;
      end else begin
         userOpValid <= accept && isUser;
         if (accept && isUser) begin
            userOpCmd <= inCmd;
         end
      end
   end

   // Reply value is left zero since it carries no meaning
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reply_q <= '0;
      end else if (accept && fromFrame) begin
         reply_q.status <= STATUS_OK;
         reply_q.opcode <= inCmd.opcode;
         reply_q.value <= 32'h0000_0000;
      end
   end

   assign replyValid = (state_q == ST_REPLY);
   assign reply = reply_q;
   assign accum = acc_q;
   assign xIndex = x_q;

   a_rotate_vel_order: assert property (@(posedge sys_clk) disable iff (rst)
      accept && isOurs && inCmd.opcode == OP_ROTATE_RIGHT
      |-> ##1 (state_q == ST_VELMODE) ##1 velocityMode ##1 paramWrValid)
      else $error("rotate-right did not select velocity mode then write velocity");

   a_rotate_vel_data: assert property (@(posedge sys_clk) disable iff (rst)
      paramWrValid |-> paramWrIndex == PARAM_TARGET_VEL && paramWrData == $past(acc_q)
      && velocityMode && dirIncrement)
      else $error("velocity write does not carry accumulator");

   a_rotate_ignores_fields: assert property (@(posedge sys_clk) disable iff (rst)
      accept && inCmd.opcode == OP_ROTATE_RIGHT |-> !memWrEn ##1 !userOpValid)
      else $error("rotate-right acted on its other fields");

   a_store_direct_var: assert property (@(posedge sys_clk) disable iff (rst)
      accept && inCmd.opcode == OP_STORE_DIRECT && idxOk
      |-> memWrEn && memWrData == inCmd.value)
      else $error("direct value not written to indexed variable");

   a_index_range: assert property (@(posedge sys_clk) disable iff (rst)
      accept && !idxOk |-> !memWrEn ##1 state_q != ST_READ)
      else $error("out of range index changed state");

   a_load_var_accum: assert property (@(posedge sys_clk) disable iff (rst)
      accept && inCmd.opcode == OP_LOAD_VAR && idxOk
      |-> ##2 state_q == ST_LOAD ##1 acc_q == $past(memRdData))
      else $error("indexed variable not loaded into accumulator");

   a_store_accum_var: assert property (@(posedge sys_clk) disable iff (rst)
      accept && inCmd.opcode == OP_STORE_ACCUM && idxOk |-> memWrEn && memWrData == acc_q)
      else $error("accumulator not stored to indexed variable");

   a_user_ext_pass: assert property (@(posedge sys_clk) disable iff (rst)
      accept && isUser |-> ##1 userOpValid && userOpCmd == $past(inCmd))
      else $error("user extension opcode not passed out");

   a_reply_ok: assert property (@(posedge sys_clk) disable iff (rst)
      accept && fromFrame && isOurs
      |-> ##[1:4] replyValid && reply.status == STATUS_OK)
      else $error("direct mode command got no status 100 reply");

   a_program_no_reply: assert property (@(posedge sys_clk) disable iff (rst)
      replyValid |-> direct_q)
      else $error("standalone command produced a reply");

   a_reply_holds: assert property (@(posedge sys_clk) disable iff (rst)
      replyValid && !replyReady |=> replyValid && $stable(reply))
      else $error("reply dropped before taken");

   a_bad_sum_drop: assert property (@(posedge sys_clk) disable iff (rst)
      csumError |-> !frameValid)
      else $error("frame with bad checksum delivered");

   c_rotate_right: cover property (@(posedge sys_clk) disable iff (rst)
      paramWrValid && direct_q);
   c_load_var: cover property (@(posedge sys_clk) disable iff (rst)
      state_q == ST_LOAD);
   c_bad_index: cover property (@(posedge sys_clk) disable iff (rst)
      accept && !idxOk && inCmd.opcode == OP_STORE_DIRECT);
   c_reply_stall: cover property (@(posedge sys_clk) disable iff (rst)
      replyValid && !replyReady ##1 replyValid && replyReady);
endmodule
`default_nettype wire

// *** test/auv_host_model.sv ***
// Host model: sends command frames and takes replies
`timescale 1ns/1ps
`default_nettype none
module auv_host_model
   import auv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rxReady,
   output logic rxValid,
   output logic [7:0] rxData,
   input wire logic replyValid,
   input wire auv_pkg::auv_reply_t reply,
   output logic replyReady
);
   initial begin
      rxValid = 1'b0;
      rxData = 8'hA5;
      replyReady = 1'b0;
   end

   task automatic send_frame(input logic [7:0] addr, input auv_cmd_t cmd, input logic badSum,
         output logic ok);
      logic [7:0] b [FRAME_BYTES];
      logic [7:0] sum;
      logic rdy;
      int i;
      int n;
      {b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = cmd;
      b[0] = addr;
      sum = 8'h00;
      for (i = 0; i < FRAME_BYTES - 1; i++) begin
         sum = sum + b[i];
      end
      b[8] = badSum ? ~sum : sum;
      ok = 1'b1;
      for (i = 0; i < FRAME_BYTES; i++) begin
         @(negedge sys_clk);
         rxValid = 1'b1;
         rxData = b[i];
         rdy = 1'b0;
         n = 0;
         while (!rdy && n < 50) begin
            #1;
            rdy = (rxReady === 1'b1);
            @(posedge sys_clk);
            n++;
            if (!rdy) @(negedge sys_clk);
         end
         if (!rdy) ok = 1'b0;
      end
      @(negedge sys_clk);
      rxValid = 1'b0;
      // Released line must not look like a held byte
      rxData = ~rxData;
   endtask

   task automatic take_reply(input int delay, output auv_reply_t got, output logic ok);
      int n;
      n = 0;
      got = '0;
      while (replyValid !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      ok = (replyValid === 1'b1);
      if (ok) begin
         repeat (delay) @(negedge sys_clk);
         replyReady = 1'b1;
         @(posedge sys_clk);
         got = reply;
         @(negedge sys_clk);
         replyReady = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** test/accum_velocity_and_user_vars_tb.sv ***
// Self-checking bench for the command executor
`timescale 1ns/1ps
`default_nettype none
module accum_velocity_and_user_vars_tb;
   import auv_pkg::*;
   typedef struct {
      logic [7:0] op;
      logic [31:0] x;
      logic [31:0] acc;
      logic [31:0] val;
      logic [31:0] expAcc;
   } auv_row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic rxValid, rxReady, csumError, progValid, progReady, replyValid, replyReady;
   logic [7:0] rxData, paramWrIndex, paramIdx;
   auv_cmd_t progCmd, userOpCmd, userLast, c;
   auv_reply_t reply;
   logic accWrValid, xWrValid, velocityMode, dirIncrement, paramWrValid, userOpValid;
   logic [31:0] accWrData, xWrData, accum, xIndex, paramWrData, paramData;
   int fails = 0;
   int checks_done = 0;
   int csumCnt = 0;
   int paramCnt = 0;
   int userCnt = 0;
   // Out-of-range stores use low index bits that are read back later
   auv_row_t rows [10] = '{
      '{OP_STORE_DIRECT, 32'h0, 32'h1, 32'hA5, 32'h1},
      '{OP_STORE_DIRECT, 32'h5, 32'h1, 32'h1234_5678, 32'h1},
      '{OP_LOAD_VAR, 32'h5, 32'h2, 32'h0, 32'h1234_5678},
      '{OP_STORE_ACCUM, 32'hFF, 32'hCAFE_0001, 32'h0, 32'hCAFE_0001},
      '{OP_LOAD_VAR, 32'hFF, 32'h3, 32'h0, 32'hCAFE_0001},
      '{OP_STORE_DIRECT, 32'h100, 32'h4, 32'hDEAD, 32'h4},
      '{OP_STORE_ACCUM, 32'hFFFF_FFFF, 32'h5, 32'h0, 32'h5},
      '{OP_LOAD_VAR, 32'h0, 32'h6, 32'h0, 32'hA5},
      '{OP_LOAD_VAR, 32'hFF, 32'h7, 32'h0, 32'hCAFE_0001},
      '{OP_LOAD_VAR, 32'h100, 32'h8, 32'h0, 32'h8}
   };

   always #2.5 sys_clk = ~sys_clk;

   auv_cmd_exec i_dut (.sys_clk(sys_clk), .rst(rst), .rxValid(rxValid), .rxData(rxData),
      .rxReady(rxReady), .csumError(csumError), .progValid(progValid), .progCmd(progCmd),
      .progReady(progReady), .replyValid(replyValid), .reply(reply), .replyReady(replyReady),
      .accWrValid(accWrValid), .accWrData(accWrData), .xWrValid(xWrValid), .xWrData(xWrData),
      .accum(accum), .xIndex(xIndex), .velocityMode(velocityMode),
      .dirIncrement(dirIncrement), .paramWrValid(paramWrValid), .paramWrIndex(paramWrIndex),
      .paramWrData(paramWrData), .userOpValid(userOpValid), .userOpCmd(userOpCmd));

   auv_host_model i_host (.sys_clk(sys_clk), .rxReady(rxReady), .rxValid(rxValid),
      .rxData(rxData), .replyValid(replyValid), .reply(reply), .replyReady(replyReady));

   // Pulses last one cycle, so they are counted here
   always @(posedge sys_clk) begin
      if (csumError === 1'b1) csumCnt++;
      if (paramWrValid === 1'b1) begin
         paramCnt++;
         paramIdx = paramWrIndex;
         paramData = paramWrData;
      end
      if (userOpValid === 1'b1) begin
         userCnt++;
         userLast = userOpCmd;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_reply(input auv_reply_t got, input auv_reply_t exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t reply got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic need(input logic ok);
      if (ok !== 1'b1) begin
         fails++;
         $display("BAD %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask

   task automatic load_regs(input logic [31:0] acc, input logic [31:0] x);
      @(negedge sys_clk);
      {accWrValid, accWrData, xWrValid, xWrData} = {1'b1, acc, 1'b1, x};
      @(negedge sys_clk);
      {accWrValid, xWrValid} = 2'b00;
   endtask

   task automatic do_cmd(input auv_cmd_t cmd, input int delay);
      auv_reply_t got;
      logic ok;
      i_host.send_frame(DEF_MODULE_ADDR, cmd, 1'b0, ok);
      need(ok);
      i_host.take_reply(delay, got, ok);
      need(ok);
      chk_reply(got, auv_reply_t'{STATUS_OK, cmd.opcode, 32'h0});
   endtask

   task automatic silent();
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(negedge sys_clk);
         if (replyValid !== 1'b0) seen = 1'b1;
      end
      chk_word({31'h0, seen}, 32'h0, "stray reply");
   endtask

   initial begin
      logic ok;
      {progValid, progCmd, accWrValid, accWrData, xWrValid, xWrData} = '0;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         load_regs(rows[i].acc, rows[i].x);
         do_cmd(auv_cmd_t'{rows[i].op, 8'(i), 8'h3, rows[i].val}, (i % 2) * 4);
         chk_word(accum, rows[i].expAcc, "accum");
         chk_word(xIndex, rows[i].x, "x reg");
      end
      $display("test variables done");
      chk_word({30'h0, velocityMode, dirIncrement}, 32'h0, "mode before");
      load_regs(32'h1F40, 32'h0);
      do_cmd(auv_cmd_t'{OP_ROTATE_RIGHT, 8'h7, 8'h3, 32'hFFFF}, 0);
      chk_word({30'h0, velocityMode, dirIncrement}, 32'h3, "mode");
      chk_word(paramCnt, 32'h1, "param writes");
      chk_word({24'h000000, paramIdx}, {24'h000000, PARAM_TARGET_VEL}, "param index");
      chk_word(paramData, 32'h1F40, "param data");
      $display("test rotate done");
      for (int k = 0; k < 8; k++) begin
         c = auv_cmd_t'{8'(OP_USER_FIRST + k), 8'(k), 8'(8'h10 + k), 32'(32'h100 + k)};
         do_cmd(c, k % 3);
         chk_word(userCnt, 32'(k + 1), "user count");
         chk_word(userLast.value, c.value, "user value");
         chk_word({8'h00, userLast[55:32]}, {8'h00, c[55:32]}, "user head");
      end
      // The neighbour above the extension range, 8'h48, is not an extension
      i_host.send_frame(DEF_MODULE_ADDR, auv_cmd_t'{8'h48, 8'h0, 8'h0, 32'h0}, 1'b0, ok);
      need(ok);
      silent();
      chk_word(userCnt, 32'h8, "user count");
      $display("test extensions done");
      load_regs(32'h0, 32'h5);
      i_host.send_frame(DEF_MODULE_ADDR, auv_cmd_t'{OP_STORE_DIRECT, 8'h0, 8'h0, 32'h99},
         1'b1, ok);
      need(ok);
      silent();
      chk_word(csumCnt, 32'h1, "sum errors");
      i_host.send_frame(8'h02, auv_cmd_t'{OP_STORE_DIRECT, 8'h0, 8'h0, 32'h98}, 1'b0, ok);
      need(ok);
      silent();
      do_cmd(auv_cmd_t'{OP_LOAD_VAR, 8'h0, 8'h0, 32'h0}, 0);
      chk_word(accum, 32'h1234_5678, "dropped frame");
      $display("test refusals done");
      load_regs(32'h0, 32'h7);
      @(negedge sys_clk);
      progCmd = auv_cmd_t'{OP_STORE_DIRECT, 8'h0, 8'h0, 32'h77};
      progValid = 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 50 && !ok; n++) begin
         #1;
         ok = (progReady === 1'b1);
         @(posedge sys_clk);
         @(negedge sys_clk);
      end
      need(ok);
      progValid = 1'b0;
      progCmd = ~progCmd;
      silent();
      do_cmd(auv_cmd_t'{OP_LOAD_VAR, 8'h0, 8'h0, 32'h0}, 2);
      chk_word(accum, 32'h77, "program store");
      $display("test program done");
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      chk_word(accum, ACC_RESET, "accum after reset");
      chk_word(xIndex, X_RESET, "x after reset");
      chk_word({velocityMode, dirIncrement, replyValid, rxReady, progReady}, 32'h3, "flags");
      $display("test reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
